// ==== common/mmp_defs.svh ====
// register offsets, field positions, reset values and encodings of the paging control
`ifndef MMP_DEFS_SVH
`define MMP_DEFS_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define MMP_AXI_AW        8
`define MMP_MODE_IDX      6'h0B
`define MMP_DIRECT_IDX    6'h11
`define MMP_PAGE_IDX      6'h15
`define MMP_MODE_ADDR     {`MMP_MODE_IDX, 2'b00}
`define MMP_DIRECT_ADDR   {`MMP_DIRECT_IDX, 2'b00}
`define MMP_PAGE_ADDR     {`MMP_PAGE_IDX, 2'b00}

// ****************************************
// fields and reset values
// ****************************************
`define MMP_MODE_BIT      7
`define MMP_MODE_SPECIAL  1'b0
`define MMP_MODE_NORMAL   1'b1
`define MMP_DIRECT_RST    8'h00
`define MMP_PAGE_RST      4'hE
`define MMP_PAGE_LOW      4'hC
`define MMP_PAGE_MID      4'hD
`define MMP_PAGE_TOP      4'hF

// ****************************************
// bus response codes
// ****************************************
`define MMP_RESP_OKAY     2'h0
`define MMP_RESP_SLVERR   2'h2

`endif

// ==== common/mmp_pkg.sv ====
// types shared by the paging control block
package mmp_pkg;

  // ****************************************
  // register selection after address decode
  // ****************************************
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_MODE,
    SEL_DIRECT,
    SEL_PAGE
  } mmp_sel_t;

  // local address window of a 16 KB quarter
  typedef logic [1:0] mmp_quarter_t;

endpackage

// ==== rtl/mmp_paging_ctrl.sv ====
// memory map paging control: mode select, direct page and flash window page over axi4-lite
`include "mmp_defs.svh"

module mmp_paging_ctrl (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [`MMP_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [`MMP_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // pins from outside the clock domain
  input  wire logic                    background_serial_pin,
  input  wire logic                    secured_in,
  // dedicated page path from the processor
  input  wire logic                    call_page_we,
  input  wire logic [3:0]              call_page_data,
  // local addresses of cpu and debug masters
  input  wire logic [15:0]             cpu_local_addr,
  input  wire logic                    cpu_direct_access,
  input  wire logic [15:0]             dbg_local_addr,
  input  wire logic                    dbg_direct_access,
  // translated global addresses
  output logic [17:0]                  cpu_global_addr,
  output logic [17:0]                  dbg_global_addr,
  // mode and page state
  output logic                         normal_single_chip,
  output logic                         background_debug,
  output logic [3:0]                   page_window_index
);

  // ****************************************
  // decode helpers
  // ****************************************

  // shared by read and write decode so both agree on the map
  function automatic mmp_pkg::mmp_sel_t decode_sel(input logic [`MMP_AXI_AW-1:0] addr);
    mmp_pkg::mmp_sel_t sel;
    sel = mmp_pkg::SEL_NONE;
    if (addr == `MMP_MODE_ADDR) begin
      sel = mmp_pkg::SEL_MODE;
    end else if (addr == `MMP_DIRECT_ADDR) begin
      sel = mmp_pkg::SEL_DIRECT;
    end else if (addr == `MMP_PAGE_ADDR) begin
      sel = mmp_pkg::SEL_PAGE;
    end
    return sel;
  endfunction

  // local to global: fixed pages around the one paged window
  function automatic logic [17:0] translate(input logic [15:0] loc, input logic [3:0] pg);
    logic [3:0] page;
    page = `MMP_PAGE_TOP;
    unique case (mmp_pkg::mmp_quarter_t'(loc[15:14]))
      2'h0: page = `MMP_PAGE_LOW;
      2'h1: page = `MMP_PAGE_MID;
      2'h2: page = pg;
      2'h3: page = `MMP_PAGE_TOP;
    endcase
    return {page, loc[13:0]};
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic sec_s1_reg;
  logic sec_s2_reg;

  // free running so the pin is tracked through reset
  always_ff @(posedge aclk) begin
    pin_s1_reg <= background_serial_pin;
    pin_s2_reg <= pin_s1_reg;
    sec_s1_reg <= secured_in;
    sec_s2_reg <= sec_s1_reg;
  end

  // ****************************************
  // bus channel state
  // ****************************************
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [`MMP_AXI_AW-1:0] awaddr_reg;
  logic [7:0]             wdata_reg;
  logic                   wlane_reg;
  logic                   awready_reg;
  logic                   wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   arready_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;

  // ****************************************
  // control registers
  // ****************************************
  logic       mode_reg;
  logic       debug_reg;
  logic       lock_reg;
  logic       dir_once_reg;
  logic [7:0] direct_reg;
  logic [3:0] page_reg;

  // ****************************************
  // write path decode
  // ****************************************
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take  = s_axi_wvalid & wready_reg;
  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire mmp_pkg::mmp_sel_t wr_sel = decode_sel(awaddr_reg);
  wire is_special = (mode_reg == `MMP_MODE_SPECIAL);
  wire wr_bit     = wdata_reg[`MMP_MODE_BIT];

  // mode write gating
  wire mode_hit   = wr_fire & wlane_reg & (wr_sel == mmp_pkg::SEL_MODE);
  wire mode_wr    = mode_hit & ~sec_s2_reg;
  wire mode_legal = (wr_bit == mode_reg) | is_special;
  wire mode_open  = ~lock_reg | is_special;
  wire mode_apply = mode_wr & mode_legal & mode_open;
  wire lock_set   = mode_wr & ~mode_legal;

  // direct page write-once in normal mode
  wire dir_hit   = wr_fire & wlane_reg & (wr_sel == mmp_pkg::SEL_DIRECT);
  wire dir_apply = dir_hit & (is_special | ~dir_once_reg);

  // page write, dedicated path wins over the bus
  wire page_hit = wr_fire & wlane_reg & (wr_sel == mmp_pkg::SEL_PAGE);
  wire [3:0] page_next = call_page_we ? call_page_data :
                         page_hit ? wdata_reg[3:0] : page_reg;

  // ****************************************
  // read path decode
  // ****************************************
  wire ar_take = s_axi_arvalid & arready_reg;
  wire mmp_pkg::mmp_sel_t rd_sel = decode_sel(s_axi_araddr);
  wire [7:0] rd_byte = (rd_sel == mmp_pkg::SEL_MODE)   ? {mode_reg, 7'h00} :
                       (rd_sel == mmp_pkg::SEL_DIRECT) ? direct_reg :
                       (rd_sel == mmp_pkg::SEL_PAGE)   ? {4'h0, page_reg} : 8'h00;
  wire [1:0] rd_resp = (rd_sel == mmp_pkg::SEL_NONE) ? `MMP_RESP_SLVERR : `MMP_RESP_OKAY;
  wire [1:0] wr_resp = (wr_sel == mmp_pkg::SEL_NONE) ? `MMP_RESP_SLVERR : `MMP_RESP_OKAY;

  // ****************************************
  // write channels: address and data in either order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ready drops once a beat is held, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= ~aw_held_reg & ~aw_take & ~bvalid_reg & ~wr_fire;
      wready_reg  <= ~w_held_reg & ~w_take & ~bvalid_reg & ~wr_fire;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MMP_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `MMP_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_reg & ~ar_take;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {24'h00_0000, rd_byte};
        rresp_reg  <= rd_resp;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // mode select and lock
  // ****************************************

  // the pin is reloaded every reset cycle, so release keeps the last sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= pin_s2_reg;
      debug_reg <= ~pin_s2_reg;
      lock_reg <= 1'b0;
    end else begin
      if (mode_apply) begin
        mode_reg <= wr_bit;
        debug_reg <= ~wr_bit;
      end
      if (lock_set) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // direct page and program page
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direct_reg   <= `MMP_DIRECT_RST;
      dir_once_reg <= 1'b0;
      page_reg     <= `MMP_PAGE_RST;
    end else begin
      if (dir_apply) begin
        direct_reg <= wdata_reg;
      end
      if (dir_hit & ~is_special) begin
        dir_once_reg <= 1'b1;
      end
      page_reg <= page_next;
    end
  end

  // ****************************************
  // address translation for both masters
  // ****************************************
  wire [1:0][15:0] loc_addr = {dbg_local_addr, cpu_local_addr};
  wire [1:0]       loc_dir  = {dbg_direct_access, cpu_direct_access};
  logic [1:0][17:0] glob_reg;

  // one registered translator per master; cost is one cycle of latency
  generate
    for (genvar m = 0; m < 2; m++) begin : g_map
      wire [15:0] eff = loc_dir[m] ? {direct_reg, loc_addr[m][7:0]} : loc_addr[m];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          glob_reg[m] <= 18'h0_0000;
        end else begin
          glob_reg[m] <= translate(eff, page_reg);
        end
      end
    end
  endgenerate

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  assign s_axi_awready      = awready_reg;
  assign s_axi_wready       = wready_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = arready_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign cpu_global_addr    = glob_reg[0];
  assign dbg_global_addr    = glob_reg[1];
  assign normal_single_chip = mode_reg;
  assign background_debug   = debug_reg;
  assign page_window_index  = page_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // mode read shows the bit on top, zeros beneath
  property p_mode_read;
    ar_take && (rd_sel == mmp_pkg::SEL_MODE) |=>
      s_axi_rvalid && (s_axi_rdata == {24'h0, $past(mode_reg), 7'h0});
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode read data wrong");

  // mode taken from the synchronised pin at release
  property p_mode_capture;
    $rose(aresetn) |-> (normal_single_chip == $past(pin_s2_reg));
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("mode not captured from pin");

  // illegal request from normal locks and keeps normal
  property p_mode_lock;
    mode_wr && !is_special && !wr_bit |=> lock_reg && normal_single_chip;
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("illegal mode write not locked");

  // secured part never changes mode
  property p_mode_secured;
    mode_hit && sec_s2_reg |=> $stable(mode_reg) && $stable(lock_reg);
  endproperty
  a_mode_secured: assert property (p_mode_secured)
    else $error("mode changed while secured");

  // special to normal goes through when unsecured
  property p_mode_upgrade;
    mode_wr && is_special && wr_bit |=> normal_single_chip && !background_debug;
  endproperty
  a_mode_upgrade: assert property (p_mode_upgrade)
    else $error("special to normal refused");

  // second direct write in normal mode is dropped
  property p_direct_once;
    dir_hit && !is_special && dir_once_reg |=> $stable(direct_reg);
  endproperty
  a_direct_once: assert property (p_direct_once)
    else $error("direct rewritten in normal mode");

  // direct access takes its high byte from the direct page
  property p_direct_map;
    cpu_direct_access && (direct_reg[7:6] == 2'h3) |=>
      cpu_global_addr == {`MMP_PAGE_TOP, $past(direct_reg[5:0]), $past(cpu_local_addr[7:0])};
  endproperty
  a_direct_map: assert property (p_direct_map)
    else $error("direct page not applied");

  // window follows the page index for the debug map
  property p_window;
    !dbg_direct_access && (dbg_local_addr[15:14] == 2'h2) |=>
      dbg_global_addr == {$past(page_reg), $past(dbg_local_addr[13:0])};
  endproperty
  a_window: assert property (p_window)
    else $error("window page wrong");

  // fixed quarters ignore the index
  property p_fixed;
    !cpu_direct_access && (cpu_local_addr[15:14] != 2'h2) |=>
      cpu_global_addr[17:14] inside {`MMP_PAGE_LOW, `MMP_PAGE_MID, `MMP_PAGE_TOP} &&
      cpu_global_addr[15:14] == $past(cpu_local_addr[15:14]);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed page wrong");

  // dedicated page write lands on the next edge
  property p_call;
    call_page_we |=> page_window_index == $past(call_page_data);
  endproperty
  a_call: assert property (p_call)
    else $error("call page write lost");

  // page reads show the index under zeros
  property p_page_read;
    ar_take && (rd_sel == mmp_pkg::SEL_PAGE) |=> s_axi_rdata == {28'h0, $past(page_reg)};
  endproperty
  a_page_read: assert property (p_page_read)
    else $error("page read data wrong");

  // index leaves reset at its linear value
  property p_page_reset;
    $rose(aresetn) |-> page_window_index == `MMP_PAGE_RST;
  endproperty
  a_page_reset: assert property (p_page_reset)
    else $error("page reset value wrong");

  // main scenarios
  c_upgrade: cover property (mode_apply && is_special && wr_bit);
  c_lock: cover property (lock_set);
  c_call_and_bus: cover property (call_page_we && page_hit);
  c_unmapped: cover property (ar_take && rd_sel == mmp_pkg::SEL_NONE);

endmodule // mmp_paging_ctrl

// ==== test/mmp_cpu_model.sv ====
// processor side model: local addresses of both masters and the page call path
module mmp_cpu_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // requests from the bench
  input  wire logic [15:0] c_addr,
  input  wire logic        c_dir,
  input  wire logic [15:0] d_addr,
  input  wire logic        d_dir,
  input  wire logic        call_req,
  input  wire logic [3:0]  call_val,
  // towards the paging control
  output logic [15:0]      cpu_local_addr,
  output logic             cpu_direct_access,
  output logic [15:0]      dbg_local_addr,
  output logic             dbg_direct_access,
  output logic             call_page_we,
  output logic [3:0]       call_page_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // one bus access per cycle, launched from the clock edge as in the core
  always_ff @(posedge aclk) begin
    cpu_local_addr    <= c_addr;
    cpu_direct_access <= c_dir;
    dbg_local_addr    <= d_addr;
    dbg_direct_access <= d_dir;
  end

  // page write is a single pulse; idle data keeps toggling so nothing leans on it
  always_ff @(posedge aclk) begin
    call_page_we <= call_req & aresetn;
    if (!aresetn) begin
      call_page_data <= 4'h5;
    end else begin
      call_page_data <= call_req ? call_val : ~call_page_data;
    end
  end
endmodule // mmp_cpu_model

// ==== test/tb.sv ====
// self-checking bench for the paging control block
`include "mmp_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0, aresetn = 1'b0, background_serial_pin = 1'b0, secured_in = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0, call_val = 4'h0;
  logic [15:0] c_addr = 16'h0, d_addr = 16'h0;
  logic        c_dir = 1'b0, d_dir = 1'b0, call_req = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] cpu_local_addr, dbg_local_addr;
  logic        cpu_direct_access, dbg_direct_access, call_page_we;
  logic [3:0]  call_page_data, page_window_index;
  logic [17:0] cpu_global_addr, dbg_global_addr;
  logic        normal_single_chip, background_debug;
  logic [31:0] seed = 32'hFF64;
  logic [31:0] v, rdat;
  logic [7:0]  dp_e;
  logic [3:0]  pg_e;
  logic [1:0]  resp;
  int          failures = 0;
  int          comparisons = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  mmp_paging_ctrl dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .background_serial_pin,
    .secured_in, .call_page_we, .call_page_data, .cpu_local_addr, .cpu_direct_access,
    .dbg_local_addr, .dbg_direct_access, .cpu_global_addr, .dbg_global_addr,
    .normal_single_chip, .background_debug, .page_window_index);

  mmp_cpu_model u_cpu (
    .aclk, .aresetn, .c_addr, .c_dir, .d_addr, .d_dir, .call_req, .call_val,
    .cpu_local_addr, .cpu_direct_access, .dbg_local_addr, .dbg_direct_access,
    .call_page_we, .call_page_data);

  // ********
  // helpers
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected global address from the bench's own copy of direct and page
  function automatic logic [17:0] xl(input logic [15:0] a, input logic d);
    logic [15:0] l;
    logic [3:0]  p;
    l = d ? {dp_e, a[7:0]} : a;
    case (l[15:14])
      2'h0: p = `MMP_PAGE_LOW;
      2'h1: p = `MMP_PAGE_MID;
      2'h2: p = pg_e;
      default: p = `MMP_PAGE_TOP;
    endcase
    return {p, l[13:0]};
  endfunction

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rst(input logic p);
    @(posedge aclk);
    background_serial_pin <= p;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    dp_e = `MMP_DIRECT_RST;
    pg_e = `MMP_PAGE_RST;
    repeat (2) @(posedge aclk);
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, g;
    g = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64 && !g; n++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      g = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (g) s_axi_bready <= 1'b0;
    end
    if (!g) begin
      failures++;
      test_done();
    end
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, g;
    g = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 64 && !g; n++) begin
      @(negedge aclk);
      t = s_axi_arready;
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
      if (g) s_axi_rready <= 1'b0;
    end
    if (!g) begin
      failures++;
      test_done();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdat, resp);
    chk(rdat, e);
    chk({30'h0, resp}, {30'h0, `MMP_RESP_OKAY});
  endtask

  // translation: model registers at edge one, design answers at edge two
  task automatic xt(input logic [15:0] ca, input logic [15:0] da, input logic cd,
                    input logic dd);
    @(posedge aclk);
    c_addr <= ca;
    d_addr <= da;
    c_dir <= cd;
    d_dir <= dd;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(32'(cpu_global_addr), 32'(xl(ca, cd)));
    chk(32'(dbg_global_addr), 32'(xl(da, dd)));
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    test_done();
  end

  initial begin
    rst(1'b0);
    rc(`MMP_MODE_ADDR, 32'h0);
    rc(`MMP_PAGE_ADDR, 32'hE);
    rc(`MMP_DIRECT_ADDR, 32'h0);
    @(negedge aclk);
    chk({30'h0, normal_single_chip, background_debug}, 32'h1);
    chk(32'(page_window_index), 32'hE);
    for (int i = 0; i < 4; i++) begin
      xt({i[1:0], 14'h02A5}, {~i[1:0], 14'h11C3}, 1'b0, 1'b0);
    end
    $display("reset test done");
    // special mode: direct writable without limit, random paging and direct accesses
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      wr(`MMP_DIRECT_ADDR, v, 4'hF, `MMP_RESP_OKAY);
      dp_e = v[7:0];
      wr(`MMP_PAGE_ADDR, ~v, 4'hF, `MMP_RESP_OKAY);
      pg_e = ~v[3:0];
      rc(`MMP_DIRECT_ADDR, {24'h0, dp_e});
      rc(`MMP_PAGE_ADDR, {28'h0, pg_e});
      v = rnd();
      xt(v[15:0], v[31:16], v[4], v[9]);
    end
    wr(`MMP_PAGE_ADDR, {28'h0, ~pg_e}, 4'hE, `MMP_RESP_OKAY);
    rc(`MMP_PAGE_ADDR, {28'h0, pg_e});
    wr(8'h00, v, 4'hF, `MMP_RESP_SLVERR);
    rd(8'h00, rdat, resp);
    chk(rdat, 32'h0);
    chk({30'h0, resp}, {30'h0, `MMP_RESP_SLVERR});
    wr(`MMP_MODE_ADDR, 32'h7F, 4'hF, `MMP_RESP_OKAY);
    rc(`MMP_MODE_ADDR, 32'h0);
    $display("special mode test done");
    // dedicated page path
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      @(posedge aclk);
      call_req <= 1'b1;
      call_val <= v[3:0];
      @(posedge aclk);
      call_req <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      chk(32'(page_window_index), {28'h0, v[3:0]});
      pg_e = v[3:0];
      xt(16'h8000 | v[29:16], 16'hBFFF, 1'b0, 1'b0);
    end
    // call path and a bus page write land in one cycle: the call path wins
    fork
      wr(`MMP_PAGE_ADDR, 32'h3, 4'hF, `MMP_RESP_OKAY);
      begin
        @(posedge aclk);
        call_req <= 1'b1;
        call_val <= 4'h9;
        @(posedge aclk);
        call_req <= 1'b0;
      end
    join
    pg_e = 4'h9;
    rc(`MMP_PAGE_ADDR, {28'h0, pg_e});
    $display("call path test done");
    // mode writes: blocked while secured, then special to normal only
    @(posedge aclk);
    secured_in <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(`MMP_MODE_ADDR, 32'h80, 4'hF, `MMP_RESP_OKAY);
    rc(`MMP_MODE_ADDR, 32'h0);
    @(posedge aclk);
    secured_in <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(`MMP_MODE_ADDR, 32'h80, 4'hF, `MMP_RESP_OKAY);
    rc(`MMP_MODE_ADDR, 32'h80);
    @(negedge aclk);
    chk({30'h0, normal_single_chip, background_debug}, 32'h2);
    wr(`MMP_MODE_ADDR, 32'h0, 4'hF, `MMP_RESP_OKAY);
    rc(`MMP_MODE_ADDR, 32'h80);
    $display("mode test done");
    // reset straight into normal mode; pin ignored after release
    rst(1'b1);
    rc(`MMP_MODE_ADDR, 32'h80);
    rc(`MMP_PAGE_ADDR, 32'hE);
    @(posedge aclk);
    background_serial_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    rc(`MMP_MODE_ADDR, 32'h80);
    wr(`MMP_DIRECT_ADDR, 32'h33, 4'hF, `MMP_RESP_OKAY);
    wr(`MMP_DIRECT_ADDR, 32'h44, 4'hF, `MMP_RESP_OKAY);
    dp_e = 8'h33;
    rc(`MMP_DIRECT_ADDR, 32'h33);
    xt(16'h0011, 16'h00FE, 1'b1, 1'b1);
    wr(`MMP_MODE_ADDR, 32'h0, 4'hF, `MMP_RESP_OKAY);
    rc(`MMP_MODE_ADDR, 32'h80);
    $display("normal reset test done");
    test_done();
  end
endmodule // tb
